// >>> epic_top.v
`timescale 1ns/1ns
`default_nettype none
`include "epic_defs.vh"

module epic_top (
	// Clock and reset
	input  wire        ref_clk_i,
	input  wire        reset_i,
	// APB slave
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	output reg  [31:0] prdata_o,
	output wire        pready_o,
	output wire        pslverr_o,
	// External interrupt pins
	input  wire        ext_irq_pin_first_i,
	input  wire        ext_irq_pin_second_i,
	// Shared port outputs on the same pins
	output wire        shared_port_bit_first_o,
	output wire        shared_port_bit_first_oe_o,
	output wire        shared_port_bit_second_o,
	output wire        shared_port_bit_second_oe_o,
	// Interrupt requests and acceptance from the core
	input  wire        ext0_irq_ack_i,
	input  wire        ext1_irq_ack_i,
	output wire        ext0_irq_o,
	output wire        ext1_irq_o,
	// Power-down state and timer 1 sync select
	output wire        powerdown_o,
	output wire        powerdown_ram_keep_o,
	output wire        timer1_sync_sel_o
);

	// Register state.
	reg  [3:0] pin0_irq_control_reg_r;
	reg  [3:0] pin1_irq_control_reg_r;
	reg  [3:0] irq_enable_reg_first_r;
	reg  [3:0] keyon_r;
	reg  [3:0] port_r;
	reg  [1:0] request_flag_r;
	reg  [1:0] request_flag_nxt;
	reg  [1:0] skip_r;
	reg  [1:0] irq_r;
	reg        master_r;
	reg        armed_r;
	reg        pdown_r;
	reg        ramkeep_r;

	// Pin synchronisers.
	reg  [1:0] pin_meta_r;
	reg  [1:0] pin_sync_r;

	wire [1:0] pin_raw;
	wire [1:0] edge_evt;
	wire [1:0] in_en;
	wire [1:0] wave;
	wire [1:0] both;
	wire [1:0] keyon_en;
	wire [1:0] skip_cmd;
	wire [1:0] skip_ok;
	wire [1:0] ack;
	wire [1:0] wake_hit;
	wire       wr_en;
	wire       rd_setup;
	wire       cmd_wr;
	wire       mapped;
	reg  [31:0] rd_val;

	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	assign pin_raw  = {ext_irq_pin_second_i, ext_irq_pin_first_i};
	assign ack      = {ext1_irq_ack_i, ext0_irq_ack_i};
	assign in_en    = {pin1_irq_control_reg_r[`EPIC_CTL_INEN],
	                   pin0_irq_control_reg_r[`EPIC_CTL_INEN]};
	assign wave     = {pin1_irq_control_reg_r[`EPIC_CTL_WAVE],
	                   pin0_irq_control_reg_r[`EPIC_CTL_WAVE]};
	// Only the first channel has the both-edges option.
	assign both     = {1'b0, pin0_irq_control_reg_r[`EPIC_CTL_BOTH]};
	assign keyon_en = {keyon_r[`EPIC_KEY_PIN1], keyon_r[`EPIC_KEY_PIN0]};

	// APB decoding: zero wait states.
	assign pready_o  = 1'b1;
	assign mapped    = hit(paddr_i, `EPIC_OFF_CTRL0)
	                 | hit(paddr_i, `EPIC_OFF_CTRL1)
	                 | hit(paddr_i, `EPIC_OFF_IRQEN)
	                 | hit(paddr_i, `EPIC_OFF_KEYON)
	                 | hit(paddr_i, `EPIC_OFF_STATUS)
	                 | hit(paddr_i, `EPIC_OFF_CMD)
	                 | hit(paddr_i, `EPIC_OFF_SKIP)
	                 | hit(paddr_i, `EPIC_OFF_PORT);
	assign pslverr_o = psel_i & penable_i & ~mapped;
	assign wr_en     = psel_i & penable_i & pwrite_i & mapped;
	assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
	assign cmd_wr    = wr_en & hit(paddr_i, `EPIC_OFF_CMD);

	// A skip-test only acts while its interrupt is disabled.
	assign skip_cmd = {pwdata_i[`EPIC_CMD_SKIP1], pwdata_i[`EPIC_CMD_SKIP0]};
	assign skip_ok  = {2{cmd_wr}} & skip_cmd
	                & ~irq_enable_reg_first_r[1:0];

	// Key-on wakeup looks at the pin whether or not its interrupt input is on.
	assign wake_hit = keyon_en & ~(pin_sync_r ^ wave);

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			pin_meta_r <= 2'h0;
			pin_sync_r <= 2'h0;
		end else begin
			pin_meta_r <= pin_raw;
			pin_sync_r <= pin_meta_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_chan
			epic_edge u_edge (
				.ref_clk_i (ref_clk_i),
				.reset_i   (reset_i),
				.pin_i     (pin_sync_r[g]),
				.en_i      (in_en[g]),
				.wave_i    (wave[g]),
				.both_i    (both[g]),
				.event_o   (edge_evt[g])
			);

			// A new edge wins over a clear in the same cycle.
			always @* begin
				request_flag_nxt[g] = request_flag_r[g];
				if (skip_ok[g] | ack[g]) begin
					request_flag_nxt[g] = 1'b0;
				end
				if (edge_evt[g]) begin
					request_flag_nxt[g] = 1'b1;
				end
			end
		end
	endgenerate

	// Configuration registers.
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			pin0_irq_control_reg_r <= `EPIC_RST_CTRL;
			pin1_irq_control_reg_r <= `EPIC_RST_CTRL;
			keyon_r                <= `EPIC_RST_KEYON;
			port_r                 <= `EPIC_RST_PORT;
		end else if (wr_en) begin
			if (hit(paddr_i, `EPIC_OFF_CTRL0)) begin
				pin0_irq_control_reg_r <= pwdata_i[3:0];
			end else if (hit(paddr_i, `EPIC_OFF_CTRL1)) begin
				pin1_irq_control_reg_r <= pwdata_i[3:0];
			end else if (hit(paddr_i, `EPIC_OFF_KEYON)) begin
				keyon_r <= pwdata_i[3:0];
			end else if (hit(paddr_i, `EPIC_OFF_PORT)) begin
				port_r <= pwdata_i[3:0];
			end
		end
	end

	// Interrupt enables are cleared on power-down entry.
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			irq_enable_reg_first_r <= `EPIC_RST_IRQEN;
		end else if (cmd_wr & armed_r & (pwdata_i[`EPIC_CMD_PD]
		             | pwdata_i[`EPIC_CMD_PD2])) begin
			irq_enable_reg_first_r <= `EPIC_RST_IRQEN;
		end else if (wr_en & hit(paddr_i, `EPIC_OFF_IRQEN)) begin
			irq_enable_reg_first_r <= pwdata_i[3:0];
		end
	end

	// Request flags, skip results and interrupt outputs.
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			request_flag_r <= 2'h0;
			skip_r         <= 2'h0;
			irq_r          <= 2'h0;
		end else begin
			request_flag_r <= request_flag_nxt;
			if (cmd_wr) begin
				skip_r <= skip_ok & request_flag_r;
			end
			irq_r <= request_flag_nxt & irq_enable_reg_first_r[1:0]
			       & {2{master_r}};
		end
	end

	// Master interrupt enable, driven by the disable and enable commands.
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			master_r <= `EPIC_RST_MASTER;
		end else if (cmd_wr & pwdata_i[`EPIC_CMD_DI]) begin
			master_r <= 1'b0;
		end else if (cmd_wr & pwdata_i[`EPIC_CMD_EI]) begin
			master_r <= 1'b1;
		end
	end

	// Power-down sequencing. Every command write consumes the arming, so only
	// a power-down command in the very next command write can enter.
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			armed_r   <= 1'b0;
			pdown_r   <= 1'b0;
			ramkeep_r <= 1'b0;
		end else begin
			if (cmd_wr) begin
				armed_r <= pwdata_i[`EPIC_CMD_ARM] & ~pdown_r;
			end
			if (pdown_r) begin
				if (|wake_hit) begin
					pdown_r   <= 1'b0;
					ramkeep_r <= 1'b0;
				end
			end else if (cmd_wr & armed_r) begin
				if (pwdata_i[`EPIC_CMD_PD2]) begin
					pdown_r   <= 1'b1;
					ramkeep_r <= 1'b1;
				end else if (pwdata_i[`EPIC_CMD_PD]) begin
					pdown_r   <= 1'b1;
					ramkeep_r <= 1'b0;
				end
			end
		end
	end

	// Read data is captured in the setup phase and held through access.
	always @* begin
		rd_val = 32'h00000000;
		if (hit(paddr_i, `EPIC_OFF_CTRL0)) begin
			rd_val[3:0] = pin0_irq_control_reg_r;
		end else if (hit(paddr_i, `EPIC_OFF_CTRL1)) begin
			rd_val[3:0] = pin1_irq_control_reg_r;
		end else if (hit(paddr_i, `EPIC_OFF_IRQEN)) begin
			rd_val[3:0] = irq_enable_reg_first_r;
		end else if (hit(paddr_i, `EPIC_OFF_KEYON)) begin
			rd_val[3:0] = keyon_r;
		end else if (hit(paddr_i, `EPIC_OFF_STATUS)) begin
			rd_val[`EPIC_ST_FLAG0]   = request_flag_r[0];
			rd_val[`EPIC_ST_FLAG1]   = request_flag_r[1];
			rd_val[`EPIC_ST_PIN0]    = pin_sync_r[0];
			rd_val[`EPIC_ST_PIN1]    = pin_sync_r[1];
			rd_val[`EPIC_ST_ARMED]   = armed_r;
			rd_val[`EPIC_ST_PDOWN]   = pdown_r;
			rd_val[`EPIC_ST_RAMKEEP] = ramkeep_r;
			rd_val[`EPIC_ST_MASTER]  = master_r;
		end else if (hit(paddr_i, `EPIC_OFF_SKIP)) begin
			rd_val[1:0] = skip_r;
		end else if (hit(paddr_i, `EPIC_OFF_PORT)) begin
			rd_val[3:0] = port_r;
		end
	end

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			prdata_o <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_o <= rd_val;
		end
	end

	// Port outputs ignore the interrupt setup entirely.
	assign shared_port_bit_first_o     = port_r[0];
	assign shared_port_bit_second_o    = port_r[1];
	assign shared_port_bit_first_oe_o  = port_r[2];
	assign shared_port_bit_second_oe_o = port_r[3];

	assign ext0_irq_o           = irq_r[0];
	assign ext1_irq_o           = irq_r[1];
	assign powerdown_o          = pdown_r;
	assign powerdown_ram_keep_o = ramkeep_r;
	assign timer1_sync_sel_o    = pin0_irq_control_reg_r[`EPIC_CTL_TSYNC];

endmodule // epic_top

`default_nettype wire

// >>> epic_defs.vh
`ifndef EPIC_DEFS_VH
`define EPIC_DEFS_VH

`define EPIC_OFF_CTRL0   8'h00
`define EPIC_OFF_CTRL1   8'h04
`define EPIC_OFF_IRQEN   8'h08
`define EPIC_OFF_KEYON   8'h0C
`define EPIC_OFF_STATUS  8'h10
`define EPIC_OFF_CMD     8'h14
`define EPIC_OFF_SKIP    8'h18
`define EPIC_OFF_PORT    8'h1C

`define EPIC_CTL_INEN    3
`define EPIC_CTL_WAVE    2
`define EPIC_CTL_BOTH    1
`define EPIC_CTL_TSYNC   0

`define EPIC_KEY_PIN0    0
`define EPIC_KEY_PIN1    2

`define EPIC_CMD_SKIP0   0
`define EPIC_CMD_SKIP1   1
`define EPIC_CMD_ARM     2
`define EPIC_CMD_PD      3
`define EPIC_CMD_PD2     4
`define EPIC_CMD_DI      5
`define EPIC_CMD_EI      6

`define EPIC_ST_FLAG0    0
`define EPIC_ST_FLAG1    1
`define EPIC_ST_PIN0     4
`define EPIC_ST_PIN1     5
`define EPIC_ST_ARMED    6
`define EPIC_ST_PDOWN    7
`define EPIC_ST_RAMKEEP  8
`define EPIC_ST_MASTER   9

`define EPIC_RST_CTRL    4'h0
`define EPIC_RST_IRQEN   4'h0
`define EPIC_RST_KEYON   4'h0
`define EPIC_RST_PORT    4'h0
`define EPIC_RST_MASTER  1'b0

`endif

// >>> epic_edge.v
`timescale 1ns/1ns
`default_nettype none

module epic_edge (
	// Clock and reset
	input  wire ref_clk_i,
	input  wire reset_i,
	// Synchronised pin level and setup
	input  wire pin_i,
	input  wire en_i,
	input  wire wave_i,
	input  wire both_i,
	// Detected valid edge
	output wire event_o
);

	reg  act_r;
	reg  lvl_r;
	wire act;
	wire lvl;

	// The gating sits ahead of the detector, so touching the enable or the
	// waveform bit can itself look like an edge, as on the real pin.
	assign act = en_i & (pin_i ~^ wave_i);
	assign lvl = en_i & pin_i;

	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			act_r <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			act_r <= act;
			lvl_r <= lvl;
		end
	end

	assign event_o = both_i ? (lvl ^ lvl_r) : (act & ~act_r);

endmodule // epic_edge

`default_nettype wire

// >>> epic_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "epic_defs.vh"

module epic_checker (
	// Clock, reset and bus
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [7:0]  paddr_i,
	input wire logic [31:0] pwdata_i,
	// Observed outputs and the channel 0 acceptance input
	input wire logic        shared_port_bit_first_o,
	input wire logic        shared_port_bit_first_oe_o,
	input wire logic        shared_port_bit_second_o,
	input wire logic        shared_port_bit_second_oe_o,
	input wire logic        ext0_irq_ack_i,
	input wire logic        ext0_irq_o,
	input wire logic        ext1_irq_o,
	input wire logic        powerdown_o
);
	logic       wr;
	logic       cmd;
	logic       go;
	logic       armed_r;
	logic [1:0] ie_r;
	logic       m_r;
	assign wr = psel_i && penable_i && pwrite_i;
	assign cmd = wr && paddr_i == `EPIC_OFF_CMD;
	assign go = cmd && armed_r && |pwdata_i[4:3];
	// Bus-side shadow; entry clears the enables just as the block does.
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			armed_r <= 1'h0;
			ie_r    <= 2'h0;
			m_r     <= 1'h0;
		end else begin
			if (cmd)
				armed_r <= pwdata_i[2] && !powerdown_o;
			if (go)
				ie_r <= 2'h0;
			else if (wr && paddr_i == `EPIC_OFF_IRQEN)
				ie_r <= pwdata_i[1:0];
			if (cmd && pwdata_i[5])
				m_r <= 1'h0;
			else if (cmd && pwdata_i[6])
				m_r <= 1'h1;
		end
	end
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	port_load_a: assert property (
		wr && paddr_i == `EPIC_OFF_PORT |=> {shared_port_bit_second_oe_o,
		shared_port_bit_first_oe_o, shared_port_bit_second_o,
		shared_port_bit_first_o} == $past(pwdata_i[3:0]))
		else $error("port outputs differ from written value");
	port_hold_a: assert property (
		!(wr && paddr_i == `EPIC_OFF_PORT) |=> $stable({
		shared_port_bit_second_oe_o, shared_port_bit_first_oe_o,
		shared_port_bit_second_o, shared_port_bit_first_o}))
		else $error("port outputs moved without a write");
	pd_entry_a: assert property ($rose(powerdown_o) |-> $past(go))
		else $error("power-down entered without armed pair");
	pd_lone_a: assert property (
		cmd && !armed_r && |pwdata_i[4:3] && !powerdown_o |=> !powerdown_o)
		else $error("lone power-down command entered power-down");
	pd_pair_a: assert property (go && !powerdown_o |=> powerdown_o)
		else $error("armed pair did not enter power-down");
	irq_gate_a: assert property (
		ext0_irq_o |-> (ie_r[0] && m_r) || $past(ie_r[0] && m_r))
		else $error("interrupt raised while disabled");
	ack_drop_a: assert property (
		ext0_irq_ack_i && ext0_irq_o |-> ##[1:2] !ext0_irq_o)
		else $error("interrupt stayed after acceptance");
	di_quiet_a: assert property (
		cmd && pwdata_i[5] |-> ##[1:2] !ext0_irq_o && !ext1_irq_o)
		else $error("interrupt stayed after disable command");
	cover property ($rose(powerdown_o));
	cover property ($rose(ext0_irq_o));
	cover property (wr && paddr_i == `EPIC_OFF_PORT);
endmodule // epic_checker

bind epic_top epic_checker i_epic_checker (.ref_clk_i, .reset_i, .psel_i,
	.penable_i, .pwrite_i, .paddr_i, .pwdata_i, .shared_port_bit_first_o,
	.shared_port_bit_first_oe_o, .shared_port_bit_second_o,
	.shared_port_bit_second_oe_o, .ext0_irq_ack_i, .ext0_irq_o,
	.ext1_irq_o, .powerdown_o);
`default_nettype wire

// >>> epic_pins_model.sv
`timescale 1ns/1ns
`default_nettype none

module epic_pins_model (
	// Clock and wanted levels
	input  wire logic       ref_clk_i,
	input  wire logic [1:0] level_i,
	// Driven pins
	output var  logic       pin_first_o,
	output var  logic       pin_second_o
);
	// Sources always drive a level; changing just after an edge keeps the
	// synchroniser delay fixed, so waits in the bench stay exact.
	always @(posedge ref_clk_i) begin
		pin_first_o  <= level_i[0];
		pin_second_o <= level_i[1];
	end
endmodule // epic_pins_model
`default_nettype wire

// >>> epic_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "epic_defs.vh"
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin mismatches++; \
	$display("unexpected t=%0t got=%h exp=%h", $time, g, x); end end

module epic_tb_top;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic        psel = 1'h0;
	logic        pen = 1'h0;
	logic        pwr = 1'h0;
	logic [7:0]  pa = 8'h00;
	logic [31:0] pd = 32'h0;
	logic        ack0 = 1'h0;
	logic        ack1 = 1'h0;
	logic [1:0]  lv = 2'h3;
	logic [31:0] prd;
	logic [31:0] q;
	logic        rdy, perr, err, pin0, pin1, po0, poe0, po1, poe1;
	logic        irq0, irq1, pdn, rk, ts;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cyc = 0;
	epic_top i_epic_top (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pd),
		.prdata_o(prd), .pready_o(rdy), .pslverr_o(perr),
		.ext_irq_pin_first_i(pin0), .ext_irq_pin_second_i(pin1),
		.shared_port_bit_first_o(po0), .shared_port_bit_first_oe_o(poe0),
		.shared_port_bit_second_o(po1), .shared_port_bit_second_oe_o(poe1),
		.ext0_irq_ack_i(ack0), .ext1_irq_ack_i(ack1), .ext0_irq_o(irq0),
		.ext1_irq_o(irq1), .powerdown_o(pdn), .powerdown_ram_keep_o(rk),
		.timer1_sync_sel_o(ts));
	epic_pins_model i_epic_pins_model (.ref_clk_i(clk), .level_i(lv),
		.pin_first_o(pin0), .pin_second_o(pin1));
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			report_and_stop;
		end
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic apb(input logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1'h1;
		do
			@(posedge clk);
		while (rdy !== 1'h1);
		q = prd;
		err = perr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic st(input logic [31:0] x);
		repeat (5) @(posedge clk);
		apb(1'h0, `EPIC_OFF_STATUS, 32'h0);
		`CHK(q, x)
	endtask
	task automatic s(input logic [7:0] a, logic [31:0] d, x);
		apb(1'h1, a, d);
		st(x);
	endtask
	task automatic p(input logic [1:0] l, logic [31:0] x);
		lv <= l;
		st(x);
	endtask
	task automatic k(input logic [31:0] d, es, x);
		apb(1'h1, `EPIC_OFF_CMD, d);
		apb(1'h0, `EPIC_OFF_SKIP, 32'h0);
		`CHK(q, es)
		st(x);
	endtask
	task automatic t_reset;
		apb(1'h0, `EPIC_OFF_CTRL0, 32'h0);
		`CHK(q, 32'h0)
		apb(1'h0, 8'h20, 32'h0);
		`CHK({err, q}, 33'h100000000)
		st(32'h30);
	endtask
	task automatic t_ch0;
		s(`EPIC_OFF_CTRL0, 32'h8, 32'h30);
		p(2'h2, 32'h21);
		k(32'h1, 32'h1, 32'h20);
		p(2'h3, 32'h30);
		s(`EPIC_OFF_CTRL0, 32'hC, 32'h31);
		k(32'h1, 32'h1, 32'h30);
		s(`EPIC_OFF_CTRL0, 32'h4, 32'h30);
		s(`EPIC_OFF_CTRL0, 32'hC, 32'h31);
		k(32'h1, 32'h1, 32'h30);
		s(`EPIC_OFF_CTRL0, 32'hA, 32'h30);
		p(2'h2, 32'h21);
		k(32'h1, 32'h1, 32'h20);
		p(2'h3, 32'h31);
		k(32'h1, 32'h1, 32'h30);
	endtask
	task automatic t_ch1;
		s(`EPIC_OFF_CTRL1, 32'h4, 32'h30);
		s(`EPIC_OFF_CTRL1, 32'h8, 32'h30);
		s(`EPIC_OFF_CTRL1, 32'hC, 32'h32);
		k(32'h2, 32'h2, 32'h30);
		p(2'h1, 32'h10);
		s(`EPIC_OFF_CTRL1, 32'h0, 32'h10);
		s(`EPIC_OFF_CTRL1, 32'h8, 32'h12);
		k(32'h2, 32'h2, 32'h10);
		p(2'h3, 32'h30);
	endtask
	task automatic t_irq;
		apb(1'h1, `EPIC_OFF_IRQEN, 32'h1);
		apb(1'h1, `EPIC_OFF_CMD, 32'h40);
		p(2'h2, 32'h221);
		`CHK(irq0, 1'h1)
		k(32'h1, 32'h0, 32'h221);
		ack0 <= 1'h1;
		@(posedge clk);
		ack0 <= 1'h0;
		st(32'h220);
		`CHK(irq0, 1'h0)
		apb(1'h1, `EPIC_OFF_CMD, 32'h20);
		apb(1'h1, `EPIC_OFF_IRQEN, 32'h0);
		p(2'h3, 32'h31);
		k(32'h1, 32'h1, 32'h30);
		apb(1'h1, `EPIC_OFF_IRQEN, 32'h2);
		apb(1'h1, `EPIC_OFF_CMD, 32'h40);
		p(2'h1, 32'h212);
		`CHK(irq1, 1'h1)
		ack1 <= 1'h1;
		@(posedge clk);
		ack1 <= 1'h0;
		st(32'h210);
		`CHK(irq1, 1'h0)
		apb(1'h1, `EPIC_OFF_CMD, 32'h20);
		apb(1'h1, `EPIC_OFF_IRQEN, 32'h0);
		s(`EPIC_OFF_CTRL1, 32'hC, 32'h10);
		p(2'h3, 32'h32);
		k(32'h2, 32'h2, 32'h30);
	endtask
	task automatic t_pdown;
		apb(1'h1, `EPIC_OFF_CTRL0, 32'h0);
		apb(1'h1, `EPIC_OFF_KEYON, 32'h0);
		apb(1'h1, `EPIC_OFF_CMD, 32'h8);
		repeat (2) @(posedge clk);
		`CHK(pdn, 1'h0)
		apb(1'h1, `EPIC_OFF_CMD, 32'h4);
		apb(1'h1, `EPIC_OFF_CMD, 32'h10);
		repeat (2) @(posedge clk);
		`CHK(pdn, 1'h1)
		`CHK(rk, 1'h1)
		apb(1'h1, `EPIC_OFF_KEYON, 32'h1);
		repeat (5) @(posedge clk);
		`CHK(pdn, 1'h1)
		p(2'h2, 32'h20);
		`CHK(pdn, 1'h0)
		`CHK(rk, 1'h0)
	endtask
	task automatic t_port;
		apb(1'h1, `EPIC_OFF_CTRL0, 32'h9);
		apb(1'h1, `EPIC_OFF_PORT, 32'hA);
		@(posedge clk);
		`CHK(ts, 1'h1)
		`CHK({po0, poe0, po1, poe1}, 4'h3)
		apb(1'h1, `EPIC_OFF_PORT, 32'h5);
		@(posedge clk);
		`CHK({po0, poe0, po1, poe1}, 4'hC)
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		t_reset;
		t_ch0;
		t_ch1;
		t_irq;
		t_pdown;
		t_port;
		report_and_stop;
	end
endmodule // epic_tb_top
`default_nettype wire
